/* dv/drive_io_config_test.sv */
`default_nettype none
module drive_io_config_test
  import drive_io_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'b0, resetn_i = 1'b0, fault_reset_i = 1'b0;
  logic awvalid_i = 1'b0, wvalid_i = 1'b0, bready_i = 1'b0;
  logic arvalid_i = 1'b0, rready_i = 1'b0, hot = 1'b0;
  logic [7:0] awaddr_i = 8'h00, araddr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata_o, rd;
  logic [3:0] wstrb_i = 4'hf, cmd_src_o;
  logic [1:0] din_sel_i = 2'h0, bresp_o, rresp_o, rr;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, relay_o;
  logic irq_o, dir_reverse_o, current_loop_loss_fault_o, run_preset1_o;
  logic speed_unit_rpm_o, thermal_reduction_indicator_o, heatsink_hot_i;
  logic signed [15:0] ain1_ref_o, preset_speed_o;
  logic [5:0] sw_freq_khz_o;
  logic [4:0] din_func_o;
  logic [9:0] ain1_level_i, lvl = 10'h1f4;
  drive_status_s status_i;
  drive_meas_s meas_i;
  int n_fail = 0, checks_done = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  drive_io_config u_drive_io_config (.*);
  drive_side_model u_drive_side_model (.clk_sys_i(clk_sys_i),
    .lvl_set_i(lvl), .hot_set_i(hot), .status_o(status_i),
    .meas_o(meas_i), .ain1_level_o(ain1_level_i),
    .heatsink_hot_o(heatsink_hot_i));
  task automatic close_out;
    $display("fails %0d checks %0d", n_fail, checks_done);
    if (n_fail == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Bounded waits; a hang ends the run as a mismatch
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    awaddr_i <= a;
    wdata_i <= d;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    do @(posedge clk_sys_i); while (awready_o !== 1'b1 && ++n < 50);
    awvalid_i <= 1'b0;
    wvalid_i <= 1'b0;
    do @(posedge clk_sys_i); while (bvalid_o !== 1'b1 && ++n < 99);
    rr = bresp_o;
    bready_i <= 1'b0;
    @(posedge clk_sys_i);
    if (n >= 99)
      chk("timeout", 1, 0);
    if (n >= 99)
      close_out();
  endtask : axw
  task automatic axr(input logic [7:0] a);
    int n = 0;
    araddr_i <= a;
    arvalid_i <= 1'b1;
    rready_i <= 1'b1;
    do @(posedge clk_sys_i); while (arready_o !== 1'b1 && ++n < 50);
    arvalid_i <= 1'b0;
    do @(posedge clk_sys_i); while (rvalid_o !== 1'b1 && ++n < 99);
    rd = rdata_o;
    rr = rresp_o;
    rready_i <= 1'b0;
    @(posedge clk_sys_i);
    if (n >= 99)
      chk("timeout", 1, 0);
    if (n >= 99)
      close_out();
  endtask : axr
  task automatic w4;
    repeat (4) @(posedge clk_sys_i);
  endtask : w4
  logic [7:0] ra[5] = '{8'h00, 8'h0c, 8'h10, 8'h14, 8'h18};
  logic [15:0] re[5] = '{16'h0, 16'h8, 16'h1, 16'h3e8, 16'h32};
  logic [15:0] gd[4] = '{16'h12, 16'h20, 16'h9, 16'h7d0};
  logic [9:0] fl[4] = '{10'h0c8, 10'h000, 10'h3e8, 10'h3e8};
  logic [2:0] ff[4] = '{3'h5, 3'h7, 3'h7, 3'h5};
  logic [15:0] fr[4] = '{16'h3e8, 16'h3e8, 16'h0, 16'h0};
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    @(posedge clk_sys_i);
    for (int i = 0; i < 5; i++)
    begin
      axr(ra[i]);
      chk("reset", 32'(re[i]), rd);
      axw(ra[i], 32'(gd[i % 4]));
      axw(ra[i], 32'(gd[i % 4] + 16'h1));
      axr(ra[i]);
      // The second write is one past each limit and is dropped; a preset takes any value within max speed, so there it lands
      chk("range", 32'(i < 4 ? gd[i] : gd[0] + 16'h1), rd);
    end
    axr(8'hfc);
    chk("resp", 32'(RESP_SLVERR), 32'(rr));
    axw(8'hfc, 32'h0);
    chk("bresp", 32'(RESP_SLVERR), 32'(rr));
    axw(ADDR_CMD_SRC, 32'h9);
    chk("cmd", 32'h9, 32'(cmd_src_o));
    chk("din", 32'h12, 32'(din_func_o));
    axw(ADDR_RELAY_THR, 32'h3e8);
    for (int f = 0; f < 10; f++)
    begin
      axw(ADDR_RELAY_FN, f);
      w4();
      chk("relay", 32'(10'h393 >> f) & 32'h1, 32'(relay_o));
    end
    axw(ADDR_RELAY_FN, 32'h0);
    axw(ADDR_IRQ_MASK, 32'h1);
    axr(ADDR_IRQ_STAT);
    axw(ADDR_AIN1_FMT, 32'h3);
    lvl <= 10'h064;
    w4();
    chk("loss", 1, 32'(current_loop_loss_fault_o));
    chk("irq", 1, 32'(irq_o));
    axr(ADDR_IRQ_STAT);
    chk("irqst", 1, rd);
    w4();
    chk("irq", 0, 32'(irq_o));
    lvl <= 10'h1f4;
    fault_reset_i <= 1'b1;
    w4();
    fault_reset_i <= 1'b0;
    axw(ADDR_AIN1_FMT, 32'h4);
    lvl <= 10'h064;
    w4();
    chk("loss", 0, 32'(current_loop_loss_fault_o));
    chk("pre1", 1, 32'(run_preset1_o));
    chk("speed", 32'h13, 32'(preset_speed_o));
    for (int i = 0; i < 4; i++)
    begin
      lvl <= fl[i];
      axw(ADDR_AIN1_FMT, 32'(ff[i]));
      w4();
      chk("ref", 32'(fr[i]), 32'(ain1_ref_o));
    end
    axw(ADDR_AIN_OFFSET, 32'h64);
    lvl <= 10'h000;
    axw(ADDR_AIN1_FMT, 32'h1);
    w4();
    chk("ref", 32'hffff_ff9c, 32'(ain1_ref_o));
    chk("rev", 1, 32'(dir_reverse_o));
    chk("swf", 32'h20, 32'(sw_freq_khz_o));
    hot <= 1'b1;
    w4();
    chk("swf", 32'(SW_REDUCED), 32'(sw_freq_khz_o));
    chk("ind", 1, 32'(thermal_reduction_indicator_o));
    axw(ADDR_PRESET0, 32'h64);
    axw(ADDR_RATED_FREQ, 32'h3c);
    axr(ADDR_PRESET0);
    chk("pre", 32'h32, rd);
    axr(ADDR_PRESET0 + 8'h0c);
    chk("pre4", 32'h258, rd);
    din_sel_i <= 2'h3;
    w4();
    chk("sel", 32'h258, 32'(preset_speed_o));
    axw(ADDR_RATED_SPD, 32'h5dc);
    w4();
    chk("rpm", 1, 32'(speed_unit_rpm_o));
    close_out();
  end
endmodule : drive_io_config_test
`default_nettype wire

/* dv/drive_side_model.sv */
`default_nettype none
module drive_side_model
  import drive_io_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic [9:0] lvl_set_i,
  input wire logic hot_set_i,
  output drive_status_s status_o,
  output drive_meas_s meas_o,
  output logic [9:0] ain1_level_o,
  output logic heatsink_hot_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Enable held on input 1, healthy and ready
  assign status_o = 4'h9;
  // Freq equals threshold, current below it, input 2 above it
  assign meas_o = {12'h3e8, 12'h1f4, 12'h5dc};
  // Sensor levels settle one edge after a change
  always @(posedge clk_sys_i)
  begin
    ain1_level_o <= lvl_set_i;
    heatsink_hot_o <= hot_set_i;
  end
endmodule : drive_side_model
`default_nettype wire

/* verilog/drive_io_config.sv */
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`default_nettype none
module drive_io_config
  import drive_io_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [ADDR_W-1:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [ADDR_W-1:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  input wire drive_status_s status_i,
  input wire drive_meas_s meas_i,
  input wire logic [9:0] ain1_level_i,
  input wire logic heatsink_hot_i,
  input wire logic fault_reset_i,
  input wire logic [1:0] din_sel_i,
  output logic relay_o,
  output logic irq_o,
  output logic dir_reverse_o,
  output logic signed [15:0] ain1_ref_o,
  output logic current_loop_loss_fault_o,
  output logic run_preset1_o,
  output logic signed [15:0] preset_speed_o,
  output logic speed_unit_rpm_o,
  output logic [5:0] sw_freq_khz_o,
  output logic thermal_reduction_indicator_o,
  output logic [4:0] din_func_o,
  output logic [3:0] cmd_src_o
);

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  logic wr_take;
  logic rd_take;
  logic wr_ok;
  logic wr_hit;
  logic [31:0] rd_data;
  logic rd_hit;
  logic [15:0] wval;

  assign wr_take = awready_o && awvalid_i && wvalid_i;
  assign rd_take = arready_o && arvalid_i;
  // Partial-word writes are acknowledged but change nothing
  assign wr_ok = wr_take && (wstrb_i == 4'hf);
  assign wval = wdata_i[15:0];

  // Address and data are taken together, one write at a time
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      awready_o <= 1'b0;
      wready_o <= 1'b0;
      bvalid_o <= 1'b0;
      bresp_o <= RESP_OKAY;
    end
    else
    begin
      awready_o <= awvalid_i && wvalid_i && !awready_o && !bvalid_o;
      wready_o <= awvalid_i && wvalid_i && !awready_o && !bvalid_o;
      if (wr_take)
      begin
        bvalid_o <= 1'b1;
        bresp_o <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bready_i)
        bvalid_o <= 1'b0;
    end
  end

  // Read path, one outstanding read
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      arready_o <= 1'b0;
      rvalid_o <= 1'b0;
      rdata_o <= 32'h0;
      rresp_o <= RESP_OKAY;
    end
    else
    begin
      arready_o <= arvalid_i && !arready_o && !rvalid_o;
      if (rd_take)
      begin
        rvalid_o <= 1'b1;
        rdata_o <= rd_data;
        rresp_o <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rready_i)
        rvalid_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [2:0] ain1_fmt_reg;
  logic [5:0] sw_max_reg;
  logic [3:0] relay_fn_reg;
  logic [11:0] relay_thr_reg;
  logic signed [15:0] preset_reg [4];
  logic [15:0] rated_freq_reg;
  logic [15:0] rated_spd_reg;
  logic [15:0] gain_reg;
  logic signed [15:0] offset_reg;
  logic [15:0] max_speed_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic rated_change;

  assign rated_change = wr_ok && (awaddr_i == ADDR_RATED_FREQ)
    && (wval >= RATED_FREQ_MIN) && (wval <= RATED_FREQ_MAX)
    && (wval != rated_freq_reg);

  // Out-of-range values are ignored, the old setting stays; max speed instead drops bit 15 of the value, the input format and IRQ mask keep only bits 2:0
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      din_func_o <= 5'h0;
      cmd_src_o <= 4'h0;
      ain1_fmt_reg <= FMT_U_0_10;
      sw_max_reg <= SW_RST;
      relay_fn_reg <= RELAY_FN_RST;
      relay_thr_reg <= THR_RST;
      rated_freq_reg <= RATED_FREQ_RST;
      rated_spd_reg <= 16'h0;
      gain_reg <= GAIN_RST;
      offset_reg <= 16'sh0;
      max_speed_reg <= MAX_SPEED_RST;
      irq_mask_reg <= '0;
    end
    else if (wr_ok)
    begin
      case (awaddr_i)
        ADDR_DIN_FUNC:
          if (wval <= 16'(DIN_FUNC_MAX))
            din_func_o <= wval[4:0];
        ADDR_CMD_SRC:
          if (wval <= 16'(CMD_SRC_MAX))
            cmd_src_o <= wval[3:0];
        ADDR_AIN1_FMT: ain1_fmt_reg <= wval[2:0];
        ADDR_SW_MAX:
          if (wval >= 16'(SW_MIN) && wval <= 16'(SW_MAX))
            sw_max_reg <= wval[5:0];
        ADDR_RELAY_FN:
          if (wval <= 16'(RELAY_FN_MAX))
            relay_fn_reg <= wval[3:0];
        ADDR_RELAY_THR:
          if (wval <= 16'(THR_MAX))
            relay_thr_reg <= wval[11:0];
        ADDR_RATED_FREQ:
          if (wval >= RATED_FREQ_MIN && wval <= RATED_FREQ_MAX)
            rated_freq_reg <= wval;
        ADDR_RATED_SPD:
          if (wval <= RATED_SPD_MAX)
            rated_spd_reg <= wval;
        ADDR_AIN_GAIN:
          if (wval <= GAIN_MAX)
            gain_reg <= wval;
        ADDR_AIN_OFFSET: offset_reg <= wval;
        ADDR_MAX_SPEED: max_speed_reg <= {1'b0, wval[14:0]};
        ADDR_IRQ_MASK: irq_mask_reg <= wdata_i[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Presets: writes bounded by max speed, restored when rated frequency moves
  generate
    for (genvar p = 0; p < 4; p++)
    begin : g_preset
      localparam logic [7:0] PADDR = ADDR_PRESET0 + 8'(4 * p);
      logic signed [15:0] pdef;
      always_comb
      begin
        case (p)
          0: pdef = PRESET0_RST;
          1: pdef = PRESET1_RST;
          2: pdef = PRESET2_RST;
          default: pdef = rated_change ? signed'(16'(wval * 16'd10))
                                       : signed'(16'(RATED_FREQ_RST * 16'd10));
        endcase
      end
      always_ff @(posedge clk_sys_i)
      begin
        if (!resetn_i)
          preset_reg[p] <= (p == 3) ? signed'(16'(RATED_FREQ_RST * 16'd10))
                                    : pdef;
        else if (rated_change)
          preset_reg[p] <= pdef;
        else if (wr_ok && awaddr_i == PADDR
                 && signed'(wval) <= signed'(max_speed_reg)
                 && signed'(wval) >= -signed'(max_speed_reg))
          preset_reg[p] <= signed'(wval);
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Analog input 1 interpretation
  // ----------------------------------------------------------------
  logic signed [17:0] lvl;
  logic signed [17:0] span;
  logic signed [17:0] norm;
  logic signed [31:0] prod;
  logic signed [31:0] ref_next;
  logic is_current;
  logic is_trip;
  logic loss;

  assign lvl = signed'({8'h0, ain1_level_i});
  assign is_current = (ain1_fmt_reg >= FMT_T_4_20)
    && (ain1_fmt_reg <= FMT_R_20_4);
  assign is_trip = (ain1_fmt_reg == FMT_T_4_20)
    || (ain1_fmt_reg == FMT_T_20_4);
  assign loss = is_current && (ain1_level_i < LEVEL_3MA);

  // Map each format onto 0..1000 before gain and offset
  always_comb
  begin
    span = 18'sh0;
    case (ain1_fmt_reg)
      FMT_T_4_20, FMT_R_4_20: span = lvl - signed'({8'h0, LEVEL_4MA});
      FMT_T_20_4, FMT_R_20_4:
        span = signed'({8'h0, LEVEL_FULL}) - lvl;
      default: span = 18'sh0;
    endcase
    case (ain1_fmt_reg)
      FMT_T_4_20, FMT_R_4_20, FMT_T_20_4, FMT_R_20_4:
        // 16 mA span scaled by 5/4 onto full range
        norm = (span < 0) ? 18'sh0 : span + (span >>> 2);
      FMT_U_10_0: norm = signed'({8'h0, LEVEL_FULL}) - lvl;
      default: norm = lvl;
    endcase
    prod = 32'(norm) * signed'({16'h0, gain_reg});
    ref_next = prod / 32'sd1000 - 32'(offset_reg);
  end

  // Registered reference and direction
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      ain1_ref_o <= 16'sh0;
      dir_reverse_o <= 1'b0;
      run_preset1_o <= 1'b0;
    end
    else
    begin
      ain1_ref_o <= ref_next[15:0];
      dir_reverse_o <= (ain1_fmt_reg == FMT_B_0_10) && (ref_next < 0);
      run_preset1_o <= loss && !is_trip;
    end
  end

  // Loss fault latches until cleared; a new loss beats the clear
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
      current_loop_loss_fault_o <= 1'b0;
    else if (loss && is_trip)
      current_loop_loss_fault_o <= 1'b1;
    else if (fault_reset_i)
      current_loop_loss_fault_o <= 1'b0;
  end

  // Preset selection, loss fallback forces the first one
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      preset_speed_o <= PRESET0_RST;
      speed_unit_rpm_o <= 1'b0;
    end
    else
    begin
      preset_speed_o <= (loss && !is_trip) ? preset_reg[0]
                                           : preset_reg[din_sel_i];
      speed_unit_rpm_o <= rated_spd_reg != 16'h0;
    end
  end

  // ----------------------------------------------------------------
  // Switching frequency with thermal reduction
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      sw_freq_khz_o <= SW_RST;
      thermal_reduction_indicator_o <= 1'b0;
    end
    else
    begin
      // Never raise above the user limit when hot
      sw_freq_khz_o <= (heatsink_hot_i && sw_max_reg > SW_REDUCED)
                       ? SW_REDUCED : sw_max_reg;
      thermal_reduction_indicator_o <= heatsink_hot_i;
    end
  end

  // ----------------------------------------------------------------
  // Relay output
  // ----------------------------------------------------------------
  drive_status_s relay_status;
  logic relay_q;

  // Loop-loss fault, latched in the trip formats only, counts as a trip for the relay conditions
  always_comb
  begin
    relay_status = status_i;
    relay_status.tripped = status_i.tripped || current_loop_loss_fault_o;
  end

  relay_select u_relay (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .func_i(relay_fn_reg),
    .thr_i(relay_thr_reg),
    .status_i(relay_status),
    .meas_i(meas_i),
    .relay_o(relay_q)
  );
  assign relay_o = relay_q;

  // ----------------------------------------------------------------
  // Interrupts and read mux
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0] irq_set;
  logic relay_prev_reg;
  logic loss_prev_reg;
  logic hot_prev_reg;

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      relay_prev_reg <= 1'b0;
      loss_prev_reg <= 1'b0;
      hot_prev_reg <= 1'b0;
    end
    else
    begin
      relay_prev_reg <= relay_q;
      loss_prev_reg <= loss;
      hot_prev_reg <= heatsink_hot_i;
    end
  end

  assign irq_set = {relay_q != relay_prev_reg,
                    heatsink_hot_i && !hot_prev_reg,
                    loss && !loss_prev_reg};

  // A read clears, but an event in the same cycle still sets
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
      irq_stat_reg <= '0;
    else if (rd_take && araddr_i == ADDR_IRQ_STAT)
      irq_stat_reg <= irq_set;
    else
      irq_stat_reg <= irq_stat_reg | irq_set;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(irq_stat_reg & irq_mask_reg);
  end

  always_comb
  begin
    rd_hit = 1'b1;
    rd_data = 32'h0;
    case (araddr_i)
      ADDR_DIN_FUNC: rd_data = 32'(din_func_o);
      ADDR_CMD_SRC: rd_data = 32'(cmd_src_o);
      ADDR_AIN1_FMT: rd_data = 32'(ain1_fmt_reg);
      ADDR_SW_MAX: rd_data = 32'(sw_max_reg);
      ADDR_RELAY_FN: rd_data = 32'(relay_fn_reg);
      ADDR_RELAY_THR: rd_data = 32'(relay_thr_reg);
      8'h18: rd_data = {16'h0, preset_reg[0]};
      8'h1c: rd_data = {16'h0, preset_reg[1]};
      8'h20: rd_data = {16'h0, preset_reg[2]};
      8'h24: rd_data = {16'h0, preset_reg[3]};
      ADDR_RATED_FREQ: rd_data = 32'(rated_freq_reg);
      ADDR_RATED_SPD: rd_data = 32'(rated_spd_reg);
      ADDR_AIN_GAIN: rd_data = 32'(gain_reg);
      ADDR_AIN_OFFSET: rd_data = {16'h0, offset_reg};
      ADDR_STATUS:
        rd_data = {10'h0, sw_freq_khz_o, 2'h0, SW_REDUCED, 2'h0,
                   speed_unit_rpm_o, relay_q, dir_reverse_o,
                   thermal_reduction_indicator_o, run_preset1_o,
                   current_loop_loss_fault_o};
      ADDR_IRQ_STAT: rd_data = 32'(irq_stat_reg);
      ADDR_IRQ_MASK: rd_data = 32'(irq_mask_reg);
      ADDR_MAX_SPEED: rd_data = 32'(max_speed_reg);
      default: rd_hit = 1'b0;
    endcase
  end

  always_comb
  begin
    wr_hit = 1'b1;
    case (awaddr_i)
      ADDR_DIN_FUNC, ADDR_CMD_SRC, ADDR_AIN1_FMT, ADDR_SW_MAX,
      ADDR_RELAY_FN, ADDR_RELAY_THR, 8'h18, 8'h1c, 8'h20, 8'h24,
      ADDR_RATED_FREQ, ADDR_RATED_SPD, ADDR_AIN_GAIN, ADDR_AIN_OFFSET,
      ADDR_IRQ_MASK, ADDR_MAX_SPEED: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  din_range_a: assert property (din_func_o <= DIN_FUNC_MAX)
    else $error("input function out of range");
  reverse_dir_a: assert property (dir_reverse_o
    |-> $past(ain1_fmt_reg) == FMT_B_0_10 && ain1_ref_o < 0)
    else $error("reverse without bidirectional negative reference");
  loop_trip_a: assert property (is_trip && ain1_level_i < LEVEL_3MA
    |=> current_loop_loss_fault_o)
    else $error("loop loss did not trip");
  loop_preset_a: assert property (loss && !is_trip
    |=> run_preset1_o && preset_speed_o == $past(preset_reg[0]))
    else $error("loop loss did not select first preset");
  sw_range_a: assert property (sw_freq_khz_o >= SW_MIN
    && sw_freq_khz_o <= SW_MAX)
    else $error("switching frequency out of range");
  thermal_cut_a: assert property (heatsink_hot_i
    |=> thermal_reduction_indicator_o && sw_freq_khz_o <= SW_REDUCED)
    else $error("hot heatsink did not reduce switching");
  relay_range_a: assert property (relay_fn_reg <= RELAY_FN_MAX
    && relay_thr_reg <= THR_MAX)
    else $error("relay setting out of range");
  preset_restore_a: assert property (rated_change
    |=> preset_reg[1] == PRESET1_RST && preset_reg[3] == $past(wval) * 10)
    else $error("presets not restored");
  rpm_unit_a: assert property (rated_spd_reg != 16'h0
    |=> speed_unit_rpm_o)
    else $error("unit flag wrong");

  trip_seen_c: cover property (current_loop_loss_fault_o);
  reverse_seen_c: cover property (dir_reverse_o);
  thermal_seen_c: cover property (thermal_reduction_indicator_o ##1 irq_o);
  restore_seen_c: cover property (rated_change);

endmodule : drive_io_config
`default_nettype wire

/* verilog/drive_io_pkg.sv */
`default_nettype none
package drive_io_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_DIN_FUNC = 8'h00;
  localparam logic [7:0] ADDR_CMD_SRC = 8'h04;
  localparam logic [7:0] ADDR_AIN1_FMT = 8'h08;
  localparam logic [7:0] ADDR_SW_MAX = 8'h0c;
  localparam logic [7:0] ADDR_RELAY_FN = 8'h10;
  localparam logic [7:0] ADDR_RELAY_THR = 8'h14;
  localparam logic [7:0] ADDR_PRESET0 = 8'h18;
  localparam logic [7:0] ADDR_RATED_FREQ = 8'h28;
  localparam logic [7:0] ADDR_RATED_SPD = 8'h2c;
  localparam logic [7:0] ADDR_AIN_GAIN = 8'h30;
  localparam logic [7:0] ADDR_AIN_OFFSET = 8'h34;
  localparam logic [7:0] ADDR_STATUS = 8'h38;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h3c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h40;
  localparam logic [7:0] ADDR_MAX_SPEED = 8'h44;

  // ----------------------------------------------------------------
  // Ranges and reset values (speeds and percents in tenths)
  // ----------------------------------------------------------------
  localparam logic [4:0] DIN_FUNC_MAX = 5'h12;
  localparam logic [3:0] CMD_SRC_MAX = 4'h9;
  localparam logic [5:0] SW_MIN = 6'h04;
  localparam logic [5:0] SW_MAX = 6'h20;
  localparam logic [5:0] SW_RST = 6'h08;
  localparam logic [5:0] SW_REDUCED = 6'h04;
  localparam logic [3:0] RELAY_FN_MAX = 4'h9;
  localparam logic [3:0] RELAY_FN_RST = 4'h1;
  localparam logic [11:0] THR_MAX = 12'h7d0;
  localparam logic [11:0] THR_RST = 12'h3e8;
  localparam logic signed [15:0] PRESET0_RST = 16'sh0032;
  localparam logic signed [15:0] PRESET1_RST = 16'sh00fa;
  localparam logic signed [15:0] PRESET2_RST = 16'sh0190;
  localparam logic [15:0] RATED_FREQ_MIN = 16'h000a;
  localparam logic [15:0] RATED_FREQ_MAX = 16'h01f4;
  localparam logic [15:0] RATED_FREQ_RST = 16'h0032;
  localparam logic [15:0] RATED_SPD_MAX = 16'h7530;
  localparam logic [15:0] MAX_SPEED_RST = 16'h01f4;
  localparam logic [15:0] GAIN_RST = 16'h03e8;
  localparam logic [15:0] GAIN_MAX = 16'h1388;

  // ----------------------------------------------------------------
  // Analog input 1 (level in permille of full scale)
  // ----------------------------------------------------------------
  localparam logic [2:0] FMT_U_0_10 = 3'h0;
  localparam logic [2:0] FMT_B_0_10 = 3'h1;
  localparam logic [2:0] FMT_A_0_20 = 3'h2;
  localparam logic [2:0] FMT_T_4_20 = 3'h3;
  localparam logic [2:0] FMT_R_4_20 = 3'h4;
  localparam logic [2:0] FMT_T_20_4 = 3'h5;
  localparam logic [2:0] FMT_R_20_4 = 3'h6;
  localparam logic [2:0] FMT_U_10_0 = 3'h7;
  localparam logic [9:0] LEVEL_FULL = 10'h3e8;
  localparam logic [9:0] LEVEL_4MA = 10'h0c8;
  localparam logic [9:0] LEVEL_3MA = 10'h096;

  // Interrupt bit positions
  localparam int IRQ_LOOP = 0;
  localparam int IRQ_THERM = 1;
  localparam int IRQ_RELAY = 2;
  localparam int IRQ_W = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Drive condition flags fed to the relay selector
  typedef struct packed {
    logic motor_enabled;
    logic tripped;
    logic at_setpoint;
    logic ready;
  } drive_status_s;

  // Measurements in tenths of a percent
  typedef struct packed {
    logic [11:0] out_freq;
    logic [11:0] out_curr;
    logic [11:0] ain2;
  } drive_meas_s;

endpackage : drive_io_pkg
`default_nettype wire

/* verilog/relay_select.sv */
`default_nettype none
module relay_select
  import drive_io_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [3:0] func_i,
  input wire logic [11:0] thr_i,
  input wire drive_status_s status_i,
  input wire drive_meas_s meas_i,
  output logic relay_o
);

  logic relay_next;

  // ----------------------------------------------------------------
  // Condition multiplexer
  // ----------------------------------------------------------------
  // Threshold is only looked at for settings 4 to 8
  always_comb
  begin
    case (func_i)
      4'h0: relay_next = status_i.motor_enabled;
      4'h1: relay_next = !status_i.tripped;
      4'h2: relay_next = status_i.at_setpoint;
      4'h3: relay_next = status_i.tripped;
      4'h4: relay_next = meas_i.out_freq >= thr_i;
      4'h5: relay_next = meas_i.out_curr >= thr_i;
      4'h6: relay_next = meas_i.out_freq < thr_i;
      4'h7: relay_next = meas_i.out_curr < thr_i;
      4'h8: relay_next = meas_i.ain2 > thr_i;
      4'h9: relay_next = status_i.ready && !status_i.tripped;
      default: relay_next = 1'b0;
    endcase
  end

  // Registered so the contact never sees mux glitches
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
      relay_o <= 1'b0;
    else
      relay_o <= relay_next;
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  // Skip the first edge after reset, where the flop still holds its reset 0
  relay_reg_a: assert property ($past(resetn_i) |-> relay_o == $past(relay_next))
    else $error("relay output not one cycle after selection");
  relay_trip_a: assert property ((func_i == 4'h3) && $stable(func_i)
    |-> relay_o == $past(status_i.tripped))
    else $error("relay trip setting wrong");
  relay_ain2_a: assert property ((func_i == 4'h8) && $stable(func_i)
    |-> relay_o == ($past(meas_i.ain2) > $past(thr_i)))
    else $error("relay analog 2 compare wrong");
  relay_close_c: cover property (func_i == 4'h4 ##1 relay_o);

endmodule : relay_select
`default_nettype wire
